// ===== rtl/fpc_pkg.sv
// Constants and types for the flash protection controller.
// Assumes a 32 KB array of 32-bit words, 1 KB pages and 2 KB protection units.
package fpc_pkg;
  localparam int unsigned FPC_ADDR_W      = 15;
  localparam int unsigned FPC_WORD_W      = 32;
  localparam int unsigned FPC_PAGE_WORDS  = 256;
  localparam int unsigned FPC_PAGE_LSB    = 10;
  localparam int unsigned FPC_UNIT_LSB    = 11;
  localparam int unsigned FPC_UNITS       = 16;
  localparam int unsigned FPC_WORD_LSB    = 2;
  localparam int unsigned FPC_PAGES       = 32;
  localparam logic [15:0] FPC_WRITE_KEY   = 16'hA442;
  localparam int unsigned FPC_OP_WRITE    = 0;
  localparam int unsigned FPC_OP_ERASE    = 1;
  localparam int unsigned FPC_OP_WHOLE_ARRAY_ERASE   = 2;
  localparam int unsigned FPC_OP_COMMIT   = 3;
  localparam logic [31:0] FPC_DEBUG_ADDR  = 32'h0000_0900;
  localparam logic [1:0]  FPC_DEBUG_OPEN  = 2'h2;
  localparam logic [7:0]  FPC_USEC_RESET  = 8'h31;
  localparam int unsigned FPC_PROG_US     = 20;
  localparam int unsigned FPC_ERASE_US    = 40;
  localparam int unsigned FPC_WHOLE_ARRAY_ERASE_US   = 80;
  localparam int unsigned FPC_COMMIT_US   = 20;
  localparam logic [31:0] FPC_ALL_ONES    = 32'hFFFF_FFFF;
  localparam logic [15:0] FPC_UNITS_OPEN  = 16'hFFFF;

  typedef enum logic [4:0] {
    FPC_IDLE   = 5'h01,
    FPC_PROG   = 5'h02,
    FPC_ERASE  = 5'h04,
    FPC_WHOLE_ARRAY_ERASE = 5'h08,
    FPC_COMMIT = 5'h10
  } fpc_state_t;
endpackage

// ===== rtl/fpc_usec_timer.sv
// Microsecond tick generator and duration counter.
// Assumes reload equals clock MHz minus one, loaded by software.
`timescale 1ns/1ps
`default_nettype none
module fpc_usec_timer
  import fpc_pkg::*;
#(
  parameter int unsigned CNT_W = 8
)(
  input  wire logic             sys_clk,    // System clock
  input  wire logic             srst,       // Synchronous reset
  input  wire logic [CNT_W-1:0] reload,     // Cycles per microsecond minus one
  input  wire logic             start,      // Begin a timed interval
  input  wire logic [7:0]       usecs,      // Interval length in microseconds
  output logic                  done        // Pulse when the interval ends
);
  logic [CNT_W-1:0] tick_cnt;
  logic [7:0]       us_left;
  logic             running;

  always_ff @(posedge sys_clk)
  begin
    if (srst || start || tick_cnt == '0)
      tick_cnt <= reload;
    else
      tick_cnt <= tick_cnt - 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    done <= 1'b0;
    if (srst)
    begin
      running <= 1'b0;
      us_left <= 8'h00;
    end
    else if (start)
    begin
      running <= 1'b1;
      us_left <= usecs;
    end
    else if (running && tick_cnt == '0)
    begin
      if (us_left <= 8'h01)
      begin
        running <= 1'b0;
        done    <= 1'b1;
      end
      us_left <= us_left - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/fpc_access_check.sv
// Read permission check for data reads of the flash array; fetches always pass.
// Assumes address and enable masks come from the same clock.
`timescale 1ns/1ps
`default_nettype none
module fpc_access_check
  import fpc_pkg::*;
(
  input  wire logic [FPC_ADDR_W-1:0] addr,       // Byte address
  input  wire logic                  is_fetch,   // Instruction fetch
  input  wire logic [FPC_UNITS-1:0]  read_en,    // Per-unit read enable
  output logic                       allowed     // Read permitted
);
  always_comb
  begin
    allowed = is_fetch || read_en[addr[FPC_ADDR_W-1:FPC_UNIT_LSB]];
  end
endmodule
`default_nettype wire

// ===== rtl/fpc_core.sv
// Flash controller: array, program/erase sequencer, protection and status.
// Assumes software drives the loose register ports one cycle at a time.
`timescale 1ns/1ps
`default_nettype none
module fpc_core
  import fpc_pkg::*;
#(
  parameter int unsigned WORDS = 8192
)(
  input  wire logic                  sys_clk,              // System clock
  input  wire logic                  srst,                 // Synchronous reset
  input  wire logic                  por,                  // Power-on reset, with srst
  input  wire logic [31:0]           flash_op_address,     // Target address register
  input  wire logic [31:0]           flash_data,           // Program data register
  input  wire logic                  flash_op_control_we,  // Control write strobe
  input  wire logic [31:0]           flash_op_control_wd,  // Control write data
  output logic [3:0]                 flash_op_control,     // Busy bits read back
  input  wire logic                  program_enable_we,    // Program enable write
  input  wire logic                  read_enable_we,       // Read enable write
  input  wire logic [31:0]           prot_wdata,           // Protection write data
  output logic [31:0]                program_enable_reg,   // Program enable readback
  output logic [31:0]                read_enable_reg,      // Read enable readback
  input  wire logic                  usec_we,              // Reload write strobe
  input  wire logic [7:0]            usec_wdata,           // Reload write data
  output logic [7:0]                 microsecond_reload,   // Reload readback
  input  wire logic [1:0]            flash_irq_mask,       // Access, done mask
  input  wire logic                  flash_status_clear_we,// Status clear strobe
  input  wire logic [1:0]            flash_status_clear,   // Write-one-to-clear
  output logic [1:0]                 flash_raw_status,     // Access, done raw
  output logic [1:0]                 flash_masked_status,  // Raw and mask
  output logic                       flash_irq,            // Interrupt request
  input  wire logic                  rd_req,               // Array read request
  input  wire logic                  rd_fetch,             // Request is a fetch
  input  wire logic [FPC_ADDR_W-1:0] rd_addr,              // Read byte address
  output logic                       rd_ready,             // Read accepted
  output logic [31:0]                rd_data,              // Read data
  output logic                       rd_valid,             // Read data valid
  output logic                       bus_fault,            // Refused data read
  output logic                       debug_access_port_en, // Debug port enable
  output logic                       tap_enable            // Test port enable
);
  logic [31:0]          mem [WORDS];
  fpc_state_t           state;
  fpc_state_t           next_state;
  logic [15:0]          pe_live;
  logic [15:0]          re_live;
  // Committed copies stand for nonvolatile cells: factory value at start
  // of life, never touched by any reset, and a commit can only clear bits
  logic [15:0]          pe_perm = FPC_UNITS_OPEN;
  logic [15:0]          re_perm = FPC_UNITS_OPEN;
  logic [1:0]           dbg_live;
  logic [1:0]           dbg_perm = FPC_DEBUG_OPEN;
  logic                 dbg_sticky;
  logic                 commit_done;
  logic                 key_ok;
  logic                 want_prog;
  logic                 want_erase;
  logic                 want_whole_array_erase;
  logic                 want_commit;
  logic                 unit_pe;
  logic                 timer_start;
  logic [7:0]           timer_us;
  logic                 timer_done;
  logic                 rd_allowed;
  logic                 set_access;
  logic                 set_done;
  logic [12:0]          word_idx;
  logic [7:0]           page_base;
  logic [4:0]           page_idx;
  logic [7:0]           erase_ptr;
  logic [12:0]          whole_array_erase_ptr;
  logic [31:0]          latch_addr;
  logic [31:0]          latch_data;

  function automatic logic [3:0] unit_of(input logic [31:0] a);
    unit_of = a[FPC_UNIT_LSB +: 4];
  endfunction

  assign key_ok      = flash_op_control_wd[31:16] == FPC_WRITE_KEY;
  assign want_prog   = flash_op_control_we && key_ok && flash_op_control_wd[FPC_OP_WRITE];
  assign want_erase  = flash_op_control_we && key_ok && flash_op_control_wd[FPC_OP_ERASE];
  assign want_whole_array_erase = flash_op_control_we && key_ok && flash_op_control_wd[FPC_OP_WHOLE_ARRAY_ERASE];
  assign want_commit = flash_op_control_we && key_ok && flash_op_control_wd[FPC_OP_COMMIT];
  assign unit_pe     = pe_live[unit_of(flash_op_address)];

  // Sequencer
  always_comb
  begin
    next_state  = state;
    timer_start = 1'b0;
    timer_us    = 8'h00;
    set_access  = 1'b0;
    unique case (state)
      FPC_IDLE:
      begin
        if (want_whole_array_erase)
        begin
          if (&pe_live)
          begin
            next_state  = FPC_WHOLE_ARRAY_ERASE;
            timer_start = 1'b1;
            timer_us    = 8'(FPC_WHOLE_ARRAY_ERASE_US);
          end
          else
            set_access = 1'b1;
        end
        else if (want_erase || want_prog)
        begin
          if (unit_pe)
          begin
            next_state  = want_erase ? FPC_ERASE : FPC_PROG;
            timer_start = 1'b1;
            timer_us    = want_erase ? 8'(FPC_ERASE_US) : 8'(FPC_PROG_US);
          end
          else
            set_access = 1'b1;
        end
        else if (want_commit)
        begin
          next_state  = FPC_COMMIT;
          timer_start = 1'b1;
          timer_us    = 8'(FPC_COMMIT_US);
        end
      end
      FPC_PROG, FPC_ERASE, FPC_WHOLE_ARRAY_ERASE, FPC_COMMIT:
        if (timer_done)
          next_state = FPC_IDLE;
      default:
        next_state = FPC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      state <= FPC_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      latch_addr <= 32'h0000_0000;
      latch_data <= 32'h0000_0000;
    end
    else if (state == FPC_IDLE && timer_start)
    begin
      latch_addr <= flash_op_address;
      latch_data <= flash_data;
    end
  end

  fpc_usec_timer #(
    .CNT_W (8)
  ) u_timer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .reload  (microsecond_reload),
    .start   (timer_start),
    .usecs   (timer_us),
    .done    (timer_done)
  );

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      microsecond_reload <= FPC_USEC_RESET;
    else if (usec_we)
      microsecond_reload <= usec_wdata;
  end

  // Array update; erase walks one word per cycle from start of interval
  assign word_idx  = 13'(latch_addr[FPC_ADDR_W-1:FPC_WORD_LSB]);
  assign page_idx  = latch_addr[FPC_PAGE_LSB +: 5];
  assign page_base = 8'h00;

  always_ff @(posedge sys_clk)
  begin
    if (srst || state == FPC_IDLE)
    begin
      erase_ptr  <= page_base;
      whole_array_erase_ptr <= 13'h0000;
    end
    else
    begin
      if (state == FPC_ERASE && erase_ptr != 8'hFF)
        erase_ptr <= erase_ptr + 8'h01;
      if (state == FPC_WHOLE_ARRAY_ERASE && whole_array_erase_ptr != 13'(WORDS - 1))
        whole_array_erase_ptr <= whole_array_erase_ptr + 13'h0001;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (state == FPC_PROG && timer_done)
      mem[word_idx] <= mem[word_idx] & latch_data;
    else if (state == FPC_ERASE)
      mem[{page_idx, erase_ptr}] <= FPC_ALL_ONES;
    else if (state == FPC_WHOLE_ARRAY_ERASE)
      mem[whole_array_erase_ptr] <= FPC_ALL_ONES;
  end

  // Protection: live bits clear-only, permanent bits survive warm reset
  assign commit_done = state == FPC_COMMIT && timer_done;

  always_ff @(posedge sys_clk)
  begin
    if (commit_done)
    begin
      if (latch_addr == FPC_DEBUG_ADDR)
      begin
        re_perm  <= re_perm & re_live;
        dbg_perm <= dbg_perm & dbg_live;
      end
      else if (latch_addr[0])
        pe_perm <= pe_perm & pe_live;
      else
        re_perm <= re_perm & re_live;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    // Any reset reloads live bits from the committed copies,
    // so clears that were never committed come back as ones
    if (srst)
    begin
      pe_live  <= pe_perm;
      re_live  <= re_perm;
      dbg_live <= dbg_perm;
    end
    else
    begin
      if (program_enable_we)
        pe_live <= pe_live & prot_wdata[15:0];
      if (read_enable_we)
      begin
        re_live  <= re_live & prot_wdata[15:0];
        dbg_live <= dbg_live & prot_wdata[31:30];
      end
    end
  end

  // Debug enable sampled at power-up only
  always_ff @(posedge sys_clk)
  begin
    if (srst && por)
    begin
      // A committed clear is seen only at the next power-up
      dbg_sticky <= dbg_perm == FPC_DEBUG_OPEN;
    end
  end

  assign debug_access_port_en = dbg_sticky;
  assign tap_enable           = 1'b1;
  assign program_enable_reg   = {16'h0000, pe_live};
  assign read_enable_reg      = {dbg_live, 14'h0000, re_live};

  // Status
  assign set_done = timer_done && (state == FPC_PROG || state == FPC_ERASE
                                   || state == FPC_WHOLE_ARRAY_ERASE);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      flash_raw_status <= 2'b00;
    else
    begin
      // Set wins over a simultaneous clear
      flash_raw_status[0] <= set_access || (flash_raw_status[0] &&
        !(flash_status_clear_we && flash_status_clear[0]));
      flash_raw_status[1] <= set_done || (flash_raw_status[1] &&
        !(flash_status_clear_we && flash_status_clear[1]));
    end
  end

  assign flash_masked_status = flash_raw_status & flash_irq_mask;
  assign flash_irq           = |flash_masked_status;

  assign flash_op_control = {state == FPC_COMMIT, state == FPC_WHOLE_ARRAY_ERASE,
                             state == FPC_ERASE, state == FPC_PROG};

  // Array reads
  fpc_access_check u_check (
    .addr     (rd_addr),
    .is_fetch (rd_fetch),
    .read_en  (re_live),
    .allowed  (rd_allowed)
  );

  assign rd_ready = state == FPC_IDLE;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rd_valid  <= 1'b0;
      bus_fault <= 1'b0;
      rd_data   <= 32'h0000_0000;
    end
    else
    begin
      rd_valid  <= rd_req && rd_ready && rd_allowed;
      bus_fault <= rd_req && rd_ready && !rd_allowed;
      if (rd_req && rd_ready && rd_allowed)
        rd_data <= mem[13'(rd_addr[FPC_ADDR_W-1:FPC_WORD_LSB])];
      else
        rd_data <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ===== tb/fpc_core_chk.sv
// Port assertions for the flash controller.
// Assumes it is bound into fpc_core; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module fpc_core_chk
  import fpc_pkg::*;
(
  input wire logic        sys_clk,               // Clock
  input wire logic        srst,                  // Reset
  input wire logic        por,                   // Power-on
  input wire logic [31:0] flash_op_address,      // Target
  input wire logic        flash_op_control_we,   // Control strobe
  input wire logic [31:0] flash_op_control_wd,   // Control data
  input wire logic [3:0]  flash_op_control,      // Busy bits
  input wire logic [31:0] program_enable_reg,    // Program enables
  input wire logic [31:0] read_enable_reg,       // Read enables
  input wire logic [7:0]  microsecond_reload,    // Reload
  input wire logic [1:0]  flash_irq_mask,        // Mask
  input wire logic        flash_status_clear_we, // Clear strobe
  input wire logic [1:0]  flash_status_clear,    // Clear bits
  input wire logic [1:0]  flash_raw_status,      // Raw
  input wire logic [1:0]  flash_masked_status,   // Masked
  input wire logic        flash_irq,             // Interrupt
  input wire logic        rd_req,                // Read request
  input wire logic        rd_fetch,              // Fetch
  input wire logic [14:0] rd_addr,               // Read address
  input wire logic        rd_ready,              // Accepted
  input wire logic        rd_valid,              // Data valid
  input wire logic        bus_fault,             // Fault
  input wire logic        tap_enable             // Test port
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire [3:0] op_unit = flash_op_address[14:11];
  sequence prog_req;
    flash_op_control_we && flash_op_control_wd == 32'hA4420001 && flash_op_control == 4'h0;
  endsequence
  sequence prog_run;
    flash_op_control[0] ##21 (flash_op_control == 4'h0 && flash_raw_status[1]);
  endsequence
  prog_time_a: assert property (
    prog_req ##0 (microsecond_reload == 8'h00 && program_enable_reg[op_unit]) |=> prog_run
  ) else $error("program timing wrong");
  prot_block_a: assert property (
    prog_req ##0 !program_enable_reg[op_unit] |=> flash_raw_status[0]
  ) else $error("blocked program did not flag");
  keyless_a: assert property (
    flash_op_control_we && flash_op_control_wd[31:16] != FPC_WRITE_KEY
      && flash_op_control == 4'h0 && !flash_status_clear_we
      |=> flash_op_control == 4'h0 && $stable(flash_raw_status)
  ) else $error("keyless write acted");
  masked_a: assert property (
    flash_masked_status == (flash_raw_status & flash_irq_mask) && flash_irq == |flash_masked_status
  ) else $error("masked status wrong");
  clear_a: assert property (
    flash_status_clear_we && flash_op_control == 4'h0 && !flash_op_control_we
      |=> flash_raw_status == ($past(flash_raw_status) & ~$past(flash_status_clear))
  ) else $error("status clear wrong");
  fault_a: assert property (
    rd_req && rd_ready && !rd_fetch && !read_enable_reg[rd_addr[14:11]] |=> bus_fault && !rd_valid
  ) else $error("protected read not faulted");
  fetch_a: assert property (
    rd_req && rd_ready && rd_fetch |=> rd_valid && !bus_fault
  ) else $error("fetch refused");
  stall_a: assert property (
    flash_op_control != 4'h0 |-> !rd_ready
  ) else $error("read taken while busy");
  tap_a: assert property (
    tap_enable
  ) else $error("test port disabled");
  factory_a: assert property (
    disable iff (1'b0) srst && por |=> program_enable_reg == 32'h0000FFFF
      && read_enable_reg == 32'h8000FFFF && microsecond_reload == 8'h31
  ) else $error("factory reset state wrong");
endmodule
`default_nettype wire

// ===== tb/fpc_bus_model.sv
// Processor-side read master for the flash array.
// Assumes start requests come from the bench one at a time.
`timescale 1ns/1ps
`default_nettype none
module fpc_bus_model
  import fpc_pkg::*;
(
  input  wire logic        sys_clk,         // Clock
  input  wire logic        go,              // Start a read
  input  wire logic        go_fetch,        // Read is a fetch
  input  wire logic [14:0] go_addr,         // Read address
  input  wire logic        rd_ready,        // Controller takes it
  output logic             rd_req = 1'b0,   // Request
  output logic             rd_fetch = 1'b0, // Fetch qualifier
  output logic [14:0]      rd_addr = 15'h0, // Address
  output logic             req_busy         // Request pending
);
  assign req_busy = rd_req;
  always_ff @(posedge sys_clk)
  begin
    if (go)
    begin
      rd_req <= 1'b1;
      rd_fetch <= go_fetch;
      rd_addr <= go_addr;
    end
    else if (rd_req && rd_ready)
    begin
      // Released lines show a changed value
      rd_req <= 1'b0;
      rd_fetch <= ~rd_fetch;
      rd_addr <= ~rd_addr;
    end
  end
endmodule
`default_nettype wire

// ===== tb/fpc_core_tb.sv
// Self-checking bench for fpc_core with a read master model.
// Assumes the checker is bound to the controller.
`timescale 1ns/1ps
`default_nettype none
module fpc_core_tb
  import fpc_pkg::*;
;
  logic sys_clk, srst, por, flash_op_control_we, program_enable_we, read_enable_we;
  logic usec_we, flash_status_clear_we, flash_irq, rd_req, rd_fetch, rd_ready;
  logic rd_valid, bus_fault, debug_access_port_en, tap_enable, go, go_fetch, req_busy;
  logic [31:0] flash_op_address, flash_data, flash_op_control_wd, prot_wdata;
  logic [31:0] program_enable_reg, read_enable_reg, rd_data, seed, d1, d2;
  logic [7:0]  usec_wdata, microsecond_reload;
  logic [3:0]  flash_op_control;
  logic [1:0]  flash_irq_mask, flash_status_clear, flash_raw_status, flash_masked_status;
  logic [14:0] rd_addr, go_addr;
  logic [32:0] exp_q[$];
  int          bad_count, samples_checked;

  fpc_core i_fpc_core (.*);
  fpc_bus_model i_fpc_bus_model (.*);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      bad_count++;
      wrap_up();
    end
  endtask

  // Sel 0 program enable, 1 read enable, 2 reload, 3 status clear
  task automatic cfg(input int sel, input logic [31:0] v);
    @(posedge sys_clk);
    prot_wdata <= v;
    usec_wdata <= v[7:0];
    flash_status_clear <= v[1:0];
    program_enable_we <= (sel == 0);
    read_enable_we <= (sel == 1);
    usec_we <= (sel == 2);
    flash_status_clear_we <= (sel == 3);
    @(posedge sys_clk);
    {program_enable_we, read_enable_we, usec_we, flash_status_clear_we} <= 4'h0;
    @(negedge sys_clk);
  endtask

  task automatic op(input logic [31:0] a, input logic [31:0] d, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    flash_op_address <= a;
    flash_data <= d;
    flash_op_control_we <= 1'b1;
    flash_op_control_wd <= wd;
    @(posedge sys_clk);
    flash_op_control_we <= 1'b0;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end while (flash_op_control !== 4'h0 && n < 2000);
    bound(n, 2000);
  endtask

  task automatic rd(input logic [14:0] a, input logic f, input logic [32:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge sys_clk);
    go <= 1'b1;
    go_fetch <= f;
    go_addr <= a;
    @(posedge sys_clk);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end while (req_busy !== 1'b0 && n < 50);
    bound(n, 50);
    repeat (2) @(negedge sys_clk);
  endtask

  always @(negedge sys_clk)
  begin
    if (rd_valid === 1'b1 || bus_fault === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        bad_count++;
        $display("[FAIL] read expected none seen %h", rd_data);
      end
      else
        chk("read", {bus_fault, bus_fault === 1'b1 ? 32'h0 : rd_data}, exp_q.pop_front());
    end
  end

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial
  begin
    {srst, por} = 2'b11;
    {flash_op_control_we, program_enable_we, read_enable_we, usec_we} = 4'h0;
    {flash_status_clear_we, go, go_fetch} = 3'h0;
    {flash_op_address, flash_data, flash_op_control_wd, prot_wdata} = '0;
    {usec_wdata, flash_irq_mask, flash_status_clear, go_addr} = '0;
    {bad_count, samples_checked} = '0;
    seed = 32'hF9EB7F4C;
    repeat (20) @(posedge sys_clk);
    {srst, por} <= 2'b00;
    @(negedge sys_clk);
    chk("reload", microsecond_reload, 8'h31);
    chk("pe", program_enable_reg, 32'h0000FFFF);
    chk("re", read_enable_reg, 32'h8000FFFF);
    chk("dap", {debug_access_port_en, tap_enable}, 2'b11);
    $display("test reset done");
    cfg(2, 32'h0000000C);
    chk("reload", microsecond_reload, 8'h0C);
    op(32'h0, 32'h0, 32'hA4420002);
    rd(15'h4, 1'b0, {1'b0, 32'hFFFFFFFF});
    chk("raw", flash_raw_status, 2'b10);
    cfg(3, 32'h1);
    chk("raw", flash_raw_status, 2'b10);
    cfg(3, 32'h2);
    chk("raw", flash_raw_status, 2'b00);
    $display("test erase done");
    cfg(2, 32'h0);
    seed = lfsr(seed);
    d1 = seed;
    seed = lfsr(seed);
    d2 = seed;
    op(32'h0, d1, 32'hA4420001);
    op(32'h0, d2, 32'hA4420001);
    rd(15'h0, 1'b0, {1'b0, d1 & d2});
    cfg(3, 32'h3);
    op(32'h0, 32'h0, 32'h12340001);
    chk("raw", flash_raw_status, 2'b00);
    $display("test program done");
    @(posedge sys_clk);
    flash_irq_mask <= 2'b01;
    cfg(0, 32'h0000FFFE);
    cfg(0, 32'h0000FFFF);
    chk("pe", program_enable_reg, 32'h0000FFFE);
    op(32'h0, 32'h0, 32'hA4420001);
    chk("irq", {flash_raw_status, flash_irq}, 3'b011);
    rd(15'h0, 1'b0, {1'b0, d1 & d2});
    @(posedge sys_clk);
    flash_irq_mask <= 2'b00;
    @(negedge sys_clk);
    chk("irq", {flash_raw_status, flash_irq}, 3'b010);
    cfg(1, 32'hFFFFFFFE);
    rd(15'h0, 1'b0, {1'b1, 32'h0});
    rd(15'h0, 1'b1, {1'b0, d1 & d2});
    $display("test protect done");
    @(posedge sys_clk);
    {srst, por} <= 2'b11;
    repeat (2) @(posedge sys_clk);
    {srst, por} <= 2'b00;
    @(negedge sys_clk);
    chk("pe", program_enable_reg, 32'h0000FFFF);
    chk("re", read_enable_reg, 32'h8000FFFF);
    $display("test power-on done");
    cfg(1, 32'h3FFFFFFE);
    op(32'h900, 32'h0, 32'hA4420008);
    chk("dap", {debug_access_port_en, read_enable_reg[31:30]}, 3'b100);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    chk("re", read_enable_reg, 32'h0000FFFE);
    chk("dap", debug_access_port_en, 1'b1);
    $display("test commit done");
    wrap_up();
  end
endmodule
bind fpc_core fpc_core_chk i_fpc_core_chk (.*);
`default_nettype wire
